// ---- hdl/ets_trigger_sync.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE_01: trigger from input 1, 2, OR, AND
// RULE_02: only external source starts measurements
// RULE_03: strict sync ties exposure to trigger
// RULE_04: prescaler uses every Nth qualified trigger
// RULE_05: programmable microsecond delay before sync event
// RULE_06: inputs 1 and 2 each enabled separately
// RULE_07: five qualification modes, edges or levels
// RULE_08: input 3 clears measurement and encoder counters
// RULE_09: input 3 enable, rising or falling edge
// RULE_10: encoder counter unidirectional or reversible
// RULE_11: idle timeout clears encoder counter
// RULE_12: idle interval in microseconds, max 4294967
// RULE_13: encoder counter wraps to zero past ceiling
// RULE_14: level modes count 10 MHz reference pulses
// RULE_15: encoder value captured at each measurement
// RULE_16: busy cycle defers to next sync event
// RULE_17: measurement counter increments per sync event
// RULE_18: reversible direction from input phase relation
// RULE_19: prescaler counts to divider then restarts
module ets_trigger_sync (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // trigger and clear inputs
    input wire logic in1,
    input wire logic in2,
    input wire logic in3,
    // configuration
    input ets_pkg::ets_cfg_s cfg,
    // measurement pipeline
    input wire logic meas_busy,
    output logic meas_start,
    output logic exposure_start,
    // counters
    output ets_pkg::ets_stat_s stat
);

    logic [2:0] in_prev;
    logic [4:0] ref_cnt;
    logic ref_tick;
    logic [1:0] qual;
    logic [1:0] is_level;
    logic trig_ev;
    logic [31:0] pre_cnt;
    logic pre_ev;
    logic pre_ok;
    ets_pkg::ets_state_e state;
    logic [7:0] dly_sub;
    logic [31:0] dly_us;
    logic sync_ev;
    logic clr3;
    logic in3_rise;
    logic in3_drop;
    logic [7:0] idle_sub;
    logic [22:0] idle_cnt;
    logic idle_done;
    logic idle_clr;
    logic enc_step;
    logic enc_down;
    logic exp_pend;
    logic [31:0] next_enc;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_prev <= 3'h0;
        end else begin
            in_prev <= {in3, in2, in1};
        end
    end

    // 10 MHz internal reference
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_cnt <= 5'h00;
        end else if (ref_cnt == ets_pkg::REF_LAST) begin
            ref_cnt <= 5'h00;
        end else begin
            ref_cnt <= ref_cnt + 5'h01;
        end
    end
    assign ref_tick = (ref_cnt == ets_pkg::REF_LAST);

    // per-input qualification
    for (genvar i = 0; i < 2; i++) begin : g_qual
        logic cur;
        logic en;
        ets_pkg::ets_in_mode_e mode;
        assign cur = (i == 0) ? in1 : in2;
        assign en = (i == 0) ? cfg.in1_en : cfg.in2_en;
        assign mode = (i == 0) ? cfg.in1_mode : cfg.in2_mode;
        always_comb begin
            is_level[i] = 1'b0;
            case (mode)
                ets_pkg::ETS_MODE_BOTH: qual[i] = cur ^ in_prev[i];
                ets_pkg::ETS_MODE_RISE: qual[i] = cur & ~in_prev[i];
                ets_pkg::ETS_MODE_FALL: qual[i] = ~cur & in_prev[i];
                ets_pkg::ETS_MODE_HIGH: begin
                    qual[i] = cur & ref_tick; // RULE_07 RULE_14
                    is_level[i] = 1'b1;
                end
                ets_pkg::ETS_MODE_LOW: begin
                    qual[i] = ~cur & ref_tick; // RULE_07 RULE_14
                    is_level[i] = 1'b1;
                end
                default: qual[i] = 1'b0;
            endcase
            if (!en) begin
                qual[i] = 1'b0; // RULE_06
            end
        end
    end

    // source combination
    always_comb begin
        case (cfg.trig_src)
            ets_pkg::ETS_TRIG_IN1: trig_ev = qual[0]; // RULE_01
            ets_pkg::ETS_TRIG_IN2: trig_ev = qual[1]; // RULE_01
            ets_pkg::ETS_TRIG_OR: trig_ev = qual[0] | qual[1]; // RULE_01
            ets_pkg::ETS_TRIG_AND: trig_ev = qual[0] & qual[1]; // RULE_01
            default: trig_ev = 1'b0;
        endcase
    end

    // event prescaler, divider of zero acts as one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt <= ets_pkg::ZERO32;
            pre_ev <= 1'b0;
        end else begin
            pre_ev <= 1'b0;
            if (cfg.sync_src != ets_pkg::ETS_SYNC_EXTERNAL) begin
                pre_cnt <= ets_pkg::ZERO32; // RULE_02
            end else if (trig_ev) begin
                if (pre_cnt + ets_pkg::ONE32 >= cfg.divider) begin
                    pre_cnt <= ets_pkg::ZERO32; // RULE_19
                    pre_ev <= 1'b1; // RULE_04
                end else begin
                    pre_cnt <= pre_cnt + ets_pkg::ONE32; // RULE_19
                end
            end
        end
    end

    // a source switch drops an event already past the prescaler
    assign pre_ok = pre_ev
                  & (cfg.sync_src == ets_pkg::ETS_SYNC_EXTERNAL); // RULE_02

    // delay line, one trigger in flight
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ets_pkg::ETS_ST_IDLE;
            dly_sub <= 8'h00;
            dly_us <= ets_pkg::ZERO32;
            sync_ev <= 1'b0;
        end else begin
            sync_ev <= 1'b0;
            case (state)
                ets_pkg::ETS_ST_IDLE: begin
                    dly_sub <= 8'h00;
                    dly_us <= ets_pkg::ZERO32;
                    if (pre_ok) begin
                        if (cfg.delay_en
                            && cfg.delay_us != ets_pkg::ZERO32) begin
                            state <= ets_pkg::ETS_ST_DELAY; // RULE_05
                        end else begin
                            sync_ev <= 1'b1;
                        end
                    end
                end
                ets_pkg::ETS_ST_DELAY: begin
                    if (cfg.sync_src != ets_pkg::ETS_SYNC_EXTERNAL) begin
                        state <= ets_pkg::ETS_ST_IDLE; // RULE_02
                    end else if (dly_sub == ets_pkg::US_LAST) begin
                        dly_sub <= 8'h00;
                        dly_us <= dly_us + ets_pkg::ONE32;
                        if (dly_us + ets_pkg::ONE32 >= cfg.delay_us) begin
                            sync_ev <= 1'b1; // RULE_05
                            state <= ets_pkg::ETS_ST_IDLE;
                        end
                    end else begin
                        dly_sub <= dly_sub + 8'h01;
                    end
                end
                default: state <= ets_pkg::ETS_ST_IDLE;
            endcase
        end
    end

    // measurement start and exposure
    assign meas_start = sync_ev & ~meas_busy; // RULE_16
    always_comb begin
        if (cfg.strict_sync) begin
            exposure_start = meas_start; // RULE_03
        end else begin
            exposure_start = exp_pend & ref_tick;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            exp_pend <= 1'b0;
        end else if (cfg.strict_sync) begin
            exp_pend <= 1'b0;
        end else if (meas_start) begin
            exp_pend <= 1'b1;
        end else if (ref_tick) begin
            exp_pend <= 1'b0;
        end
    end

    // input 3 clear
    assign in3_rise = in3 & ~in_prev[2];
    assign in3_drop = ~in3 & in_prev[2];
    always_comb begin
        clr3 = 1'b0;
        if (cfg.in3_en) begin
            if (cfg.in3_fall) begin
                clr3 = in3_drop; // RULE_09
            end else begin
                clr3 = in3_rise; // RULE_09
            end
        end
    end

    // idle timeout since last sync event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_sub <= 8'h00;
            idle_cnt <= 23'h000000;
            idle_done <= 1'b0;
        end else if (sync_ev || !cfg.idle_clr_en) begin
            idle_sub <= 8'h00;
            idle_cnt <= 23'h000000;
            idle_done <= 1'b0;
        end else if (idle_clr) begin
            idle_done <= 1'b1; // RULE_11
        end else if (!idle_done) begin
            if (idle_sub == ets_pkg::US_LAST) begin
                idle_sub <= 8'h00;
                idle_cnt <= idle_cnt + 23'h000001; // RULE_12
            end else begin
                idle_sub <= idle_sub + 8'h01;
            end
        end
    end
    assign idle_clr = cfg.idle_clr_en & ~idle_done & ~sync_ev
                    & (idle_cnt >= cfg.idle_us); // RULE_11 RULE_12

    // encoder step source and direction
    always_comb begin
        enc_step = 1'b0;
        enc_down = 1'b0;
        if (|(is_level & {cfg.in2_en, cfg.in1_en})) begin
            enc_step = trig_ev; // RULE_14
        end else if (cfg.cnt_bidir) begin
            enc_step = (cfg.in1_en | cfg.in2_en)
                     & ((in1 ^ in_prev[0]) ^ (in2 ^ in_prev[1])); // RULE_10
            enc_down = ~(in1 ^ in_prev[1]); // RULE_18
        end else begin
            enc_step = trig_ev; // RULE_10
        end
    end

    always_comb begin
        if (enc_down) begin
            next_enc = (stat.enc_count == ets_pkg::ZERO32) ? cfg.cnt_max
                     : stat.enc_count - ets_pkg::ONE32;
        end else if (stat.enc_count >= cfg.cnt_max) begin
            next_enc = ets_pkg::ZERO32; // RULE_13
        end else begin
            next_enc = stat.enc_count + ets_pkg::ONE32;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat.enc_count <= ets_pkg::ZERO32;
            stat.enc_dir_down <= 1'b0;
        end else if (clr3 || idle_clr) begin
            stat.enc_count <= ets_pkg::ZERO32; // RULE_08 RULE_11
        end else if (enc_step) begin
            stat.enc_count <= next_enc; // RULE_13
            stat.enc_dir_down <= enc_down; // RULE_18
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat.meas_count <= ets_pkg::ZERO32;
        end else if (clr3) begin
            stat.meas_count <= ets_pkg::ZERO32; // RULE_08
        end else if (sync_ev) begin
            stat.meas_count <= stat.meas_count + ets_pkg::ONE32; // RULE_17
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat.enc_capture <= ets_pkg::ZERO32;
            stat.capture_dir_down <= 1'b0;
        end else if (meas_start) begin
            stat.enc_capture <= stat.enc_count; // RULE_15
            stat.capture_dir_down <= stat.enc_dir_down; // RULE_15
        end
    end

endmodule

// ---- hdl/ets_pkg.sv ----
package ets_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned REF_HZ = 10_000_000;
    localparam int unsigned US_PER_S = 1_000_000;
    localparam int unsigned REF_CYC = CLK_HZ / REF_HZ;
    localparam int unsigned US_CYC = CLK_HZ / US_PER_S;
    localparam logic [4:0] REF_LAST = 5'(REF_CYC - 1);
    localparam logic [7:0] US_LAST = 8'(US_CYC - 1);

    // values after reset and limits of the configuration
    localparam logic [31:0] DIVIDER_RST = 32'h0000_0001;
    localparam logic [31:0] DELAY_US_RST = 32'h0000_0000;
    localparam logic [22:0] IDLE_US_MAX = 23'h418937;
    localparam logic [31:0] CNT_MAX_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] ONE32 = 32'h0000_0001;

    typedef enum logic [1:0] {
        ETS_SYNC_INTERNAL = 2'h0,
        ETS_SYNC_EXTERNAL = 2'h1,
        ETS_SYNC_EXT_REQ = 2'h2,
        ETS_SYNC_INT_REQ = 2'h3
    } ets_sync_src_e;

    typedef enum logic [1:0] {
        ETS_TRIG_IN1 = 2'h0,
        ETS_TRIG_IN2 = 2'h1,
        ETS_TRIG_OR = 2'h2,
        ETS_TRIG_AND = 2'h3
    } ets_trig_src_e;

    typedef enum logic [2:0] {
        ETS_MODE_BOTH = 3'h0,
        ETS_MODE_RISE = 3'h1,
        ETS_MODE_FALL = 3'h2,
        ETS_MODE_HIGH = 3'h3,
        ETS_MODE_LOW = 3'h4
    } ets_in_mode_e;

    typedef enum logic [1:0] {
        ETS_ST_IDLE = 2'b01,
        ETS_ST_DELAY = 2'b10
    } ets_state_e;

    typedef struct packed {
        ets_sync_src_e sync_src;
        ets_trig_src_e trig_src;
        logic strict_sync;
        logic [31:0] divider;
        logic delay_en;
        logic [31:0] delay_us;
        logic in1_en;
        ets_in_mode_e in1_mode;
        logic in2_en;
        ets_in_mode_e in2_mode;
        logic in3_en;
        logic in3_fall;
        logic cnt_bidir;
        logic idle_clr_en;
        logic [22:0] idle_us;
        logic [31:0] cnt_max;
    } ets_cfg_s;

    typedef struct packed {
        logic [31:0] enc_count;
        logic enc_dir_down;
        logic [31:0] meas_count;
        logic [31:0] enc_capture;
        logic capture_dir_down;
    } ets_stat_s;

endpackage

// ---- verif/ets_trigger_sync_properties.sv ----
`timescale 1ns/1ps
module ets_trigger_sync_properties (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // lines and configuration
    input wire logic in1,
    input wire logic in2,
    input wire logic in3,
    input ets_pkg::ets_cfg_s cfg,
    // measurement side
    input wire logic meas_busy,
    input wire logic meas_start,
    input wire logic exposure_start,
    input ets_pkg::ets_stat_s stat
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_busy_gate: assert property (meas_start |-> !meas_busy)
        else $error("start while busy");
    a_strict_expo: assert property (cfg.strict_sync && meas_start
        |-> exposure_start)
        else $error("exposure not tied to start");
    a_src_gate: assert property ((cfg.sync_src != ets_pkg::ETS_SYNC_EXTERNAL)[*3]
        |-> !meas_start)
        else $error("start from non external source");
    a_meas_step: assert property (meas_start && !cfg.in3_en |=>
        stat.meas_count == $past(stat.meas_count) + ets_pkg::ONE32)
        else $error("measurement count not stepped");
    a_capture_val: assert property (meas_start |=>
        stat.enc_capture == $past(stat.enc_count))
        else $error("capture differs from counter");
    a_rise_lat: assert property ($rose(in1) && cfg.in1_en && !cfg.delay_en
        && cfg.sync_src == ets_pkg::ETS_SYNC_EXTERNAL
        && cfg.trig_src == ets_pkg::ETS_TRIG_IN1
        && cfg.in1_mode == ets_pkg::ETS_MODE_RISE
        && cfg.divider == ets_pkg::ONE32 |-> ##2 (meas_start || meas_busy))
        else $error("rise did not start measurement");
    a_in3_clear: assert property (cfg.in3_en && !cfg.in3_fall
        && $rose(in3) |-> ##[1:2] (stat.meas_count == ets_pkg::ZERO32
        && stat.enc_count == ets_pkg::ZERO32))
        else $error("clear input ignored");
    a_enc_step: assert property ($changed(stat.enc_count)
        && !cfg.cnt_bidir |-> stat.enc_count == ets_pkg::ZERO32
        || stat.enc_count == $past(stat.enc_count) + ets_pkg::ONE32)
        else $error("up counter moved wrongly");
    a_enc_wrap: assert property ($changed(stat.enc_count)
        && !cfg.cnt_bidir && $past(stat.enc_count) >= cfg.cnt_max
        |-> stat.enc_count == ets_pkg::ZERO32)
        else $error("counter passed ceiling");

    c_strict: cover property (meas_start && exposure_start);
    c_down: cover property (cfg.cnt_bidir && stat.enc_dir_down);
    c_clear: cover property (cfg.in3_en && $rose(in3));
endmodule

// ---- verif/ets_src_model.sv ----
`timescale 1ns/1ps
module ets_src_model (
    // clock
    input wire logic clk,
    // trigger and clear lines
    output logic in1,
    output logic in2,
    output logic in3
);
    initial begin
        {in3, in2, in1} = 3'h0;
    end

    // set {in3,in2,in1} just after an edge and hold it n cycles
    task automatic put(input logic [2:0] v, input int n);
        @(posedge clk);
        {in3, in2, in1} <= v;
        repeat (n - 1) @(posedge clk);
    endtask

    // 20 ns high and 20 ns low, a period right at the 40 ns floor
    task automatic pulse(input logic [2:0] v);
        put(v, 4);
        put(3'h0, 4);
    endtask
endmodule

// ---- verif/ets_trigger_sync_tb.sv ----
`timescale 1ns/1ps
module ets_trigger_sync_tb;
    logic clk, resetn, in1, in2, in3, meas_busy, meas_start, exposure_start;
    ets_pkg::ets_cfg_s cfg, c;
    ets_pkg::ets_stat_s stat;
    int n_fail = 0;
    int checked = 0;
    int n_start = 0;
    int n_expo = 0;
    logic [31:0] e0;
    logic [2:0] q [4] = '{3'h1, 3'h3, 3'h2, 3'h0};
    logic [2:0] tsel [4] = '{3'h5, 3'h6, 3'h7, 3'h4};

    ets_trigger_sync ets_trigger_sync_i (.clk(clk), .resetn(resetn),
        .in1(in1), .in2(in2), .in3(in3), .cfg(cfg), .meas_busy(meas_busy),
        .meas_start(meas_start), .exposure_start(exposure_start), .stat(stat));
    ets_src_model ets_src_model_i (.clk(clk), .in1(in1), .in2(in2), .in3(in3));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (meas_start === 1'h1) n_start++;
        if (exposure_start === 1'h1) n_expo++;
    end

    function automatic ets_pkg::ets_cfg_s base();
        ets_pkg::ets_cfg_s v;
        v = '0;
        v.divider = ets_pkg::DIVIDER_RST;
        v.idle_us = ets_pkg::IDLE_US_MAX;
        v.cnt_max = ets_pkg::CNT_MAX_RST;
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic set(input ets_pkg::ets_cfg_s v);
        @(posedge clk);
        cfg <= v;
        repeat (3) @(posedge clk);
    endtask

    // n pulses on the chosen lines, then count the starts
    task automatic burst(input logic [2:0] v, input int n, input int exp);
        n_start = 0;
        repeat (n) ets_src_model_i.pulse(v);
        repeat (10) @(posedge clk);
        chk(n_start, exp);
    endtask

    task automatic end_sim();
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial begin
        cfg = base();
        meas_busy = 1'h0;
        resetn = 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        chk(stat.meas_count | stat.enc_count, 32'h0);
        c = base();
        c.in1_en = 1'h1;
        c.strict_sync = 1'h1;
        set(c);
        burst(3'h1, 1, 0);
        c.sync_src = ets_pkg::ETS_SYNC_EXTERNAL;
        c.in1_en = 1'h0;
        set(c);
        burst(3'h1, 1, 0);
        c.in1_en = 1'h1;
        set(c);
        burst(3'h1, 2, 4);
        chk(stat.meas_count, 32'h4);
        for (int k = 1; k < 3; k++) begin
            c.in1_mode = ets_pkg::ets_in_mode_e'(k);
            set(c);
            burst(3'h1, 3, 3);
        end
        for (int k = 0; k < 2; k++) begin
            c.in1_mode = ets_pkg::ets_in_mode_e'(k + 3);
            set(c);
            n_start = 0;
            ets_src_model_i.put({2'h0, k[0]}, 60);
            chk(n_start, 0);
            e0 = stat.enc_count;
            ets_src_model_i.put({2'h0, ~k[0]}, 100);
            chk(n_start inside {[4:6]}, 1);
            chk((stat.enc_count - e0) inside {[4:6]}, 1);
        end
        c.in1_mode = ets_pkg::ETS_MODE_RISE;
        c.in2_en = 1'h1;
        c.in2_mode = ets_pkg::ETS_MODE_RISE;
        for (int s = 0; s < 4; s++) begin
            c.trig_src = ets_pkg::ets_trig_src_e'(s);
            set(c);
            for (int b = 0; b < 3; b++)
                burst(3'(b + 1), 1, tsel[s][b]);
        end
        c.trig_src = ets_pkg::ETS_TRIG_IN1;
        c.divider = 32'h3;
        set(c);
        burst(3'h1, 6, 2);
        burst(3'h1, 2, 0);
        burst(3'h1, 1, 1);
        c.divider = ets_pkg::DIVIDER_RST;
        c.delay_en = 1'h1;
        c.delay_us = 32'h1;
        set(c);
        n_start = 0;
        ets_src_model_i.pulse(3'h1);
        repeat (150) @(posedge clk);
        chk(n_start, 0);
        repeat (100) @(posedge clk);
        chk(n_start, 1);
        c.delay_en = 1'h0;
        set(c);
        e0 = stat.meas_count;
        meas_busy <= 1'h1;
        burst(3'h1, 1, 0);
        chk(stat.meas_count, e0 + 32'h1);
        meas_busy <= 1'h0;
        c.strict_sync = 1'h0;
        set(c);
        n_expo = 0;
        burst(3'h1, 1, 1);
        repeat (20) @(posedge clk);
        chk(n_expo, 1);
        c.strict_sync = 1'h1;
        c.cnt_max = 32'h2;
        c.in3_en = 1'h1;
        set(c);
        ets_src_model_i.pulse(3'h4);
        chk(stat.meas_count | stat.enc_count, 32'h0);
        burst(3'h1, 4, 4);
        chk(stat.enc_count, 32'h1);
        chk(stat.enc_capture, 32'h1);
        c.in3_fall = 1'h1;
        set(c);
        ets_src_model_i.put(3'h4, 6);
        chk(stat.enc_count, 32'h1);
        ets_src_model_i.put(3'h0, 4);
        chk(stat.enc_count, 32'h0);
        c.in3_en = 1'h0;
        c.cnt_bidir = 1'h1;
        c.cnt_max = ets_pkg::CNT_MAX_RST;
        set(c);
        for (int i = 0; i < 4; i++) ets_src_model_i.put(q[i], 4);
        chk(stat.enc_count, 32'h4);
        for (int i = 0; i < 4; i++) ets_src_model_i.put(q[(6 - i) % 4], 4);
        chk(stat.enc_count, 32'h0);
        chk(stat.enc_dir_down, 1'h1);
        c.cnt_bidir = 1'h0;
        c.idle_clr_en = 1'h1;
        c.idle_us = 23'h2;
        set(c);
        burst(3'h1, 1, 1);
        repeat (240) @(posedge clk);
        chk(stat.enc_count, 32'h1);
        repeat (200) @(posedge clk);
        chk(stat.enc_count, 32'h0);
        end_sim();
    end
endmodule

bind ets_trigger_sync ets_trigger_sync_properties ets_trigger_sync_properties_i (
    .clk(clk), .resetn(resetn), .in1(in1), .in2(in2), .in3(in3), .cfg(cfg),
    .meas_busy(meas_busy), .meas_start(meas_start),
    .exposure_start(exposure_start), .stat(stat));
